// ---- hdl/fps_flash_seq.sv ----
// Operation
// - write enable steers external writes to flash
// - write enable stays until software clears
// - external reads always go to ram
// - byte program only clears bits
// - erase sets whole 512-byte page to ff
// - erase plus write enable erases page
// - software write/erase needs permit bit
// - device times operations, stalls core
// - top 1024 bytes reserved on large part
// - scratchpad select overlays low 128 bytes
// - scratchpad execution not supported
// - lock bits guard 8k blocks for debug
// - scratchpad locked only by all-zero byte
// - lock bytes sit at variant addresses
// - software cannot erase lock-byte page
// - locked debug read returns undefined data
// - lock bytes always readable and clearable
// - lock page guarded by top block bit
// - debug erase of lock byte erases all
// - access limit splits lower and upper
// - upper read of lower returns zero
// - limit is register in high byte
// - upper code cannot touch lower pages
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "fps_regs.svh"

module fps_flash_seq #(
    parameter logic        SMALL_VARIANT = 1'b0,
    parameter int unsigned ERASE_CYCLES  = `FPS_ERASE_CYC
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 cpu_req,
    input  wire fps_pkg::fps_kind_t   cpu_kind,
    input  wire logic [15:0]          cpu_addr,
    input  wire logic [15:0]          cpu_pc,
    input  wire logic [7:0]           cpu_wdata,
    output logic                      cpu_ack,
    output logic      [7:0]           cpu_rdata,
    output logic                      cpu_stall,
    output logic                      external_data_ram_req,
    output logic                      external_data_ram_we,
    output logic      [15:0]          external_data_ram_addr,
    output logic      [7:0]           external_data_ram_wdata,
    input  wire logic [7:0]           external_data_ram_rdata,
    input  wire logic                 dbg_req,
    input  wire fps_pkg::fps_dbg_op_t dbg_op,
    input  wire logic [15:0]          dbg_addr,
    input  wire logic                 dbg_scratch,
    input  wire logic [7:0]           dbg_wdata,
    output logic                      dbg_ack,
    output logic      [7:0]           dbg_rdata,
    output logic                      fl_rd,
    output logic                      fl_prog,
    output logic                      fl_erase,
    output logic                      fl_erase_all,
    output logic      [16:0]          fl_addr,
    output logic      [7:0]           fl_wdata,
    input  wire logic [7:0]           fl_rdata
);
    import fps_pkg::*;

    typedef enum logic [8:0] {
        ST_IDLE  = 9'h001,
        ST_LK1   = 9'h002,
        ST_LK2   = 9'h004,
        ST_LK3   = 9'h008,
        ST_PRD   = 9'h010,
        ST_PWR   = 9'h020,
        ST_BUSY  = 9'h040,
        ST_RD    = 9'h080,
        ST_DONE  = 9'h100
    } fps_state_t;

    ////////////////////////////////////////////////////////////////////////////
    // address helpers

    // flash address, bit 16 selects the scratchpad sector; data only, no fetch port
    function automatic logic [16:0] map_addr(input logic [15:0] a, input logic scr);
        map_addr = (scr && a[15:7] == 9'h000) ? {1'b1, 9'h000, a[6:0]} : {1'b0, a};
    endfunction : map_addr

    function automatic logic reserved(input logic [15:0] a);
        reserved = !SMALL_VARIANT && a >= `FPS_RESERVED_BASE;
    endfunction : reserved

    // block lock bit for an 8k block, or all-zero test for the scratchpad
    function automatic logic lock_hit(input logic [7:0] lb, input logic [16:0] fa);
        lock_hit = fa[16] ? (lb == 8'h00) : !lb[fa[15:13]];
    endfunction : lock_hit

    ////////////////////////////////////////////////////////////////////////////
    // registers

    fps_state_t  state_reg, state_next;
    logic [2:0]  psc_reg;
    logic        permit_reg, limit_set_reg, refused_reg;
    logic [7:0]  limit_reg, lock_we_reg, res_reg, data_reg;
    logic [16:0] op_addr_reg;
    logic        dbg_owner_reg, op_erase_reg;
    logic [19:0] timer_reg;
    logic [31:0] prdata_reg;
    logic        pready_reg, pslverr_reg;
    logic        cpu_ack_reg, dbg_ack_reg, stall_reg;
    logic        xreq_reg, xwe_reg;
    logic        fl_rd_reg, fl_prog_reg, fl_erase_reg, fl_all_reg;

    ////////////////////////////////////////////////////////////////////////////
    // apb decode

    wire        apb_setup  = psel && penable && !pready_reg;
    wire        apb_done   = psel && penable && pready_reg;
    wire        apb_wr     = apb_done && pwrite;
    wire        hit_psc    = paddr == `FPS_OFS_PSC;
    wire        hit_scale  = paddr == `FPS_OFS_SCALE;
    wire        hit_limit  = paddr == `FPS_OFS_LIMIT;
    wire        hit_status = paddr == `FPS_OFS_STATUS;
    wire        hit_any    = hit_psc || hit_scale || hit_limit || hit_status;
    wire        busy       = state_reg != ST_IDLE;
    wire [31:0] rd_mux     = hit_psc    ? {29'h0, psc_reg} :
                             hit_scale  ? {31'h0, permit_reg} :
                             hit_limit  ? {24'h0, limit_reg} :
                             hit_status ? {30'h0, refused_reg, busy} : 32'h0;

    ////////////////////////////////////////////////////////////////////////////
    // request decode

    wire        store_write_enable = psc_reg[`FPS_PSC_WE_BIT];
    wire        store_erase_enable = psc_reg[`FPS_PSC_EE_BIT];
    wire        scratchpad_select  = psc_reg[`FPS_PSC_SCR_BIT];
    wire        flash_write_permit = permit_reg;
    wire [15:0] access_limit_address = {limit_reg, 8'h00};
    wire [15:0] lk_we_addr = SMALL_VARIANT ? `FPS_LOCK_WE_32K : `FPS_LOCK_WE_64K;
    wire [15:0] lk_rd_addr = SMALL_VARIANT ? `FPS_LOCK_RD_32K : `FPS_LOCK_RD_64K;

    // lower/upper partition test on the core side
    wire        c_below   = cpu_addr < access_limit_address;
    wire        c_upper   = cpu_pc >= access_limit_address;
    wire        c_fal_blk = c_upper && c_below;
    wire        c_lkpage  = cpu_addr[15:9] == lk_we_addr[15:9];
    wire [16:0] c_faddr   = map_addr(cpu_addr, scratchpad_select);
    wire        c_refuse  = !flash_write_permit || reserved(cpu_addr) || c_fal_blk ||
                            (store_erase_enable && c_lkpage && !c_faddr[16]);

    // debug side, lock bytes held in lock_we_reg and fl_rdata during ST_LK3
    wire [16:0] d_faddr   = map_addr(dbg_addr, dbg_scratch);
    wire        d_lkbyte  = !d_faddr[16] && (dbg_addr == lk_we_addr || dbg_addr == lk_rd_addr);
    wire        d_rd_lock = lock_hit(fl_rdata, d_faddr);
    wire        d_we_lock = lock_hit(lock_we_reg, d_faddr);

    ////////////////////////////////////////////////////////////////////////////
    // sequencer next state

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (cpu_req) begin
                    if (cpu_kind == FPS_PROG_RD)
                        state_next = (c_fal_blk || reserved(cpu_addr)) ? ST_DONE : ST_RD;
                    else if (cpu_kind == FPS_EXT_RD || !store_write_enable)
                        state_next = ST_RD;
                    else if (c_refuse)
                        state_next = ST_DONE;
                    else
                        state_next = store_erase_enable ? ST_BUSY : ST_PRD;
                end else if (dbg_req) begin
                    state_next = ST_LK1;
                end
            end
            ST_LK1: state_next = ST_LK2;
            ST_LK2: state_next = ST_LK3;
            ST_LK3: begin
                case (dbg_op)
                    FPS_DBG_RD: state_next = (reserved(dbg_addr) || (d_rd_lock && !d_lkbyte))
                                             ? ST_DONE : ST_RD;
                    FPS_DBG_WR: state_next = (reserved(dbg_addr) || (d_we_lock && !d_lkbyte))
                                             ? ST_DONE : ST_PRD;
                    FPS_DBG_ER: state_next = d_lkbyte ? ST_BUSY :
                                             (reserved(dbg_addr) || d_we_lock) ? ST_DONE
                                             : ST_BUSY;
                    default:    state_next = ST_DONE;
                endcase
            end
            ST_PRD:  state_next = ST_PWR;
            ST_PWR:  state_next = ST_BUSY;
            ST_BUSY: state_next = (timer_reg == 20'h00001) ? ST_DONE : ST_BUSY;
            ST_RD:   state_next = ST_DONE;
            ST_DONE: state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb slave: one wait state, writes land at the completing edge

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0;
        end else begin
            pready_reg  <= apb_setup;
            pslverr_reg <= apb_setup && !hit_any;
            prdata_reg  <= (apb_setup && !pwrite) ? rd_mux : 32'h0;
        end
    end

    // control registers; limit is write-once until reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            psc_reg       <= `FPS_PSC_RST;
            permit_reg    <= 1'b0;
            limit_reg     <= `FPS_LIMIT_RST;
            limit_set_reg <= 1'b0;
        end else begin
            if (apb_wr && hit_psc)
                psc_reg <= pwdata[2:0];
            if (apb_wr && hit_scale)
                permit_reg <= pwdata[`FPS_SCALE_PERMIT_BIT];
            if (apb_wr && hit_limit && !limit_set_reg) begin
                limit_reg     <= pwdata[7:0];
                limit_set_reg <= 1'b1;
            end
        end
    end

    // refused flag: a new refusal beats a same-cycle clear
    wire refuse_evt = state_reg == ST_IDLE && state_next == ST_DONE && cpu_req &&
                      cpu_kind == FPS_EXT_WR;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            refused_reg <= 1'b0;
        else if (refuse_evt)
            refused_reg <= 1'b1;
        else if (apb_wr && hit_status && pwdata[`FPS_STAT_REFUSED_BIT])
            refused_reg <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // operation context, latched as a request is taken; the write lock byte in ST_LK2

    wire take     = state_reg == ST_IDLE && (cpu_req || dbg_req);
    wire go_busy  = state_next == ST_BUSY && state_reg != ST_BUSY;
    wire to_done  = state_next == ST_DONE;
    wire full_er  = state_reg == ST_LK3 && dbg_op == FPS_DBG_ER && d_lkbyte;
    wire [19:0] load_cnt = op_erase_reg || state_reg != ST_PWR
                           ? 20'(ERASE_CYCLES) : 20'(`FPS_WRITE_CYC);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dbg_owner_reg <= 1'b0;
            op_addr_reg   <= 17'h0;
            data_reg      <= 8'h00;
            op_erase_reg  <= 1'b0;
            lock_we_reg   <= 8'h00;
        end else begin
            if (take) begin
                dbg_owner_reg <= !cpu_req;
                op_addr_reg   <= cpu_req ? c_faddr : d_faddr;
                data_reg      <= cpu_req ? cpu_wdata : dbg_wdata;
                op_erase_reg  <= cpu_req ? store_erase_enable : dbg_op == FPS_DBG_ER;
            end
            if (state_reg == ST_LK2)
                lock_we_reg <= fl_rdata;
        end
    end

    // operation timer; the core stays stalled while it runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            timer_reg <= 20'h0;
        else if (go_busy)
            timer_reg <= load_cnt;
        else if (state_reg == ST_BUSY)
            timer_reg <= timer_reg - 20'h00001;
    end

    ////////////////////////////////////////////////////////////////////////////
    // answers: read data and one-cycle acks

    wire        blk_read = state_reg == ST_IDLE || state_reg == ST_LK3;
    wire        external_data_ram_rd  = state_reg == ST_RD && xreq_reg;
    wire [7:0]  res_next = external_data_ram_rd ? external_data_ram_rdata :
                           state_reg == ST_RD ? fl_rdata :
                           blk_read ? `FPS_BLOCKED_BYTE : res_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_reg     <= 8'h00;
            cpu_ack_reg <= 1'b0;
            dbg_ack_reg <= 1'b0;
            stall_reg   <= 1'b0;
        end else begin
            res_reg     <= to_done ? res_next : res_reg;
            cpu_ack_reg <= to_done && (state_reg == ST_IDLE ? cpu_req : !dbg_owner_reg);
            dbg_ack_reg <= to_done && state_reg != ST_IDLE && dbg_owner_reg;
            stall_reg   <= state_next == ST_BUSY || state_next == ST_PWR;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // flash and external ram strobes, single-cycle except fl_rd, held through ST_LK2, ST_LK3 and ST_RD on a debug read

    wire        x_go   = state_reg == ST_IDLE && cpu_req && state_next == ST_RD &&
                         cpu_kind != FPS_PROG_RD;
    wire        rd_go  = state_next == ST_RD && !x_go || state_next == ST_LK2 ||
                         state_next == ST_LK3 || state_next == ST_PWR;
    wire [16:0] rd_adr = state_next == ST_LK2 ? {1'b0, lk_we_addr} :
                         state_next == ST_LK3 ? {1'b0, lk_rd_addr} :
                         state_reg == ST_IDLE ? c_faddr :
                         state_reg == ST_LK3  ? d_faddr : op_addr_reg;
    wire        er_go  = go_busy && state_reg != ST_PWR;
    wire [16:0] er_adr = state_reg == ST_IDLE ? {c_faddr[16:9], 9'h000} :
                         {d_faddr[16:9], 9'h000};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fl_rd_reg    <= 1'b0;
            fl_prog_reg  <= 1'b0;
            fl_erase_reg <= 1'b0;
            fl_all_reg   <= 1'b0;
            fl_addr      <= 17'h0;
            fl_wdata     <= 8'h00;
            xreq_reg     <= 1'b0;
            xwe_reg      <= 1'b0;
            external_data_ram_addr    <= 16'h0;
            external_data_ram_wdata   <= 8'h00;
        end else begin
            fl_rd_reg    <= rd_go;
            fl_prog_reg  <= state_reg == ST_PWR;
            fl_erase_reg <= er_go && !full_er;
            fl_all_reg   <= er_go && full_er;
            fl_addr      <= state_reg == ST_PWR ? op_addr_reg : er_go ? er_adr : rd_adr;
            fl_wdata     <= state_reg == ST_PWR ? (fl_rdata & data_reg) : `FPS_ERASED_BYTE;
            xreq_reg     <= x_go;
            xwe_reg      <= x_go && cpu_kind == FPS_EXT_WR;
            external_data_ram_addr    <= x_go ? cpu_addr : external_data_ram_addr;
            external_data_ram_wdata   <= x_go ? cpu_wdata : external_data_ram_wdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            state_reg <= ST_IDLE;
        else
            state_reg <= state_next;
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign prdata       = prdata_reg;
    assign pready       = pready_reg;
    assign pslverr      = pslverr_reg;
    assign cpu_ack      = cpu_ack_reg;
    assign cpu_rdata    = res_reg;
    assign cpu_stall    = stall_reg;
    assign dbg_ack      = dbg_ack_reg;
    assign dbg_rdata    = res_reg;
    assign external_data_ram_req     = xreq_reg;
    assign external_data_ram_we      = xwe_reg;
    assign fl_rd        = fl_rd_reg;
    assign fl_prog      = fl_prog_reg;
    assign fl_erase     = fl_erase_reg;
    assign fl_erase_all = fl_all_reg;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    property p_we_sticky;
        @(posedge pclk) disable iff (!presetn)
        !(apb_wr && hit_psc) |=> store_write_enable == $past(store_write_enable);
    endproperty
    a_we_sticky: assert property (p_we_sticky) else $error("write enable changed alone");

    property p_ext_wr_ram;
        @(posedge pclk) disable iff (!presetn)
        (state_reg == ST_IDLE && cpu_req && cpu_kind == FPS_EXT_WR && !store_write_enable)
        |=> external_data_ram_req && external_data_ram_we && !fl_prog;
    endproperty
    a_ext_wr_ram: assert property (p_ext_wr_ram) else $error("external write missed ram");

    property p_ext_rd_ram;
        @(posedge pclk) disable iff (!presetn)
        (state_reg == ST_IDLE && cpu_req && cpu_kind == FPS_EXT_RD)
        |=> external_data_ram_req && !external_data_ram_we && !fl_rd ##1 cpu_ack;
    endproperty
    a_ext_rd_ram: assert property (p_ext_rd_ram) else $error("external read not from ram");

    property p_permit;
        @(posedge pclk) disable iff (!presetn)
        (fl_prog || fl_erase) && !dbg_owner_reg |-> flash_write_permit;
    endproperty
    a_permit: assert property (p_permit) else $error("flash change without permit");

    property p_no_lkpage_erase;
        @(posedge pclk) disable iff (!presetn)
        fl_erase && !dbg_owner_reg |-> fl_addr[16] || fl_addr[15:9] != lk_we_addr[15:9];
    endproperty
    a_no_lkpage_erase: assert property (p_no_lkpage_erase) else $error("lock page erased");

    property p_erase_stall;
        @(posedge pclk) disable iff (!presetn)
        fl_erase |-> cpu_stall ##1 cpu_stall [*8];
    endproperty
    a_erase_stall: assert property (p_erase_stall) else $error("core not stalled");

    property p_fal_zero;
        @(posedge pclk) disable iff (!presetn)
        (state_reg == ST_IDLE && cpu_req && cpu_kind == FPS_PROG_RD && c_fal_blk)
        |=> cpu_ack && cpu_rdata == 8'h00;
    endproperty
    a_fal_zero: assert property (p_fal_zero) else $error("protected read leaked");

    property p_erase_no_data;
        @(posedge pclk) disable iff (!presetn)
        (fl_erase || fl_erase_all) |-> !fl_prog ##1 !fl_prog [*2];
    endproperty
    a_erase_no_data: assert property (p_erase_no_data) else $error("data programmed");

    property p_full_erase_dbg;
        @(posedge pclk) disable iff (!presetn)
        fl_erase_all |-> dbg_owner_reg && $past(state_reg) == ST_LK3;
    endproperty
    a_full_erase_dbg: assert property (p_full_erase_dbg) else $error("firmware full erase");

endmodule : fps_flash_seq

// ---- hdl/fps_regs.svh ----
`ifndef FPS_REGS_SVH
`define FPS_REGS_SVH

// register byte offsets on the apb side
`define FPS_OFS_PSC         8'h00
`define FPS_OFS_SCALE       8'h04
`define FPS_OFS_LIMIT       8'h08
`define FPS_OFS_STATUS      8'h0c

// program_store_control fields
`define FPS_PSC_WE_BIT      0
`define FPS_PSC_EE_BIT      1
`define FPS_PSC_SCR_BIT     2
// flash_scale_control fields
`define FPS_SCALE_PERMIT_BIT 0
// status fields (refused is write-one-to-clear)
`define FPS_STAT_BUSY_BIT   0
`define FPS_STAT_REFUSED_BIT 1

// reset values
`define FPS_PSC_RST         3'h0
`define FPS_LIMIT_RST       8'h00

// flash timing, figures in their own units
`define FPS_CLK_MHZ         40
`define FPS_ERASE_MS        10
`define FPS_WRITE_US        40
`define FPS_ERASE_CYC       (`FPS_ERASE_MS * 1000 * `FPS_CLK_MHZ)
`define FPS_WRITE_CYC       (`FPS_WRITE_US * `FPS_CLK_MHZ)

// memory map constants
`define FPS_LOCK_WE_64K     16'hfbfe
`define FPS_LOCK_RD_64K     16'hfbff
`define FPS_LOCK_WE_32K     16'h7ffe
`define FPS_LOCK_RD_32K     16'h7fff
`define FPS_RESERVED_BASE   16'hfc00
`define FPS_ERASED_BYTE     8'hff
`define FPS_BLOCKED_BYTE    8'h00

`endif

// ---- hdl/fps_pkg.sv ----
package fps_pkg;

    // core request kinds
    typedef enum logic [1:0] {
        FPS_EXT_WR  = 2'h0,
        FPS_EXT_RD  = 2'h1,
        FPS_PROG_RD = 2'h2
    } fps_kind_t;

    // debug-port operations
    typedef enum logic [1:0] {
        FPS_DBG_RD = 2'h0,
        FPS_DBG_WR = 2'h1,
        FPS_DBG_ER = 2'h2
    } fps_dbg_op_t;

endpackage : fps_pkg

// ---- sim/fps_flash_model.sv ----
`timescale 1ns/1ps
module fps_flash_model (
    input  wire logic        pclk,
    input  wire logic        fl_rd,
    input  wire logic        fl_prog,
    input  wire logic        fl_erase,
    input  wire logic        fl_erase_all,
    input  wire logic [16:0] fl_addr,
    input  wire logic [7:0]  fl_wdata,
    output logic      [7:0]  fl_rdata
);
    logic [7:0] mem [int];
    int         base;
    int         span;
    initial fl_rdata = 8'h00;
    ////////////////////////////////////////////////////////////////
    // array updates at the strobe edge
    always @(posedge pclk) begin
        base = int'(fl_addr & (fl_addr[16] ? 17'h1ff80 : 17'h1fe00));
        span = fl_addr[16] ? 128 : 512;
        if (fl_prog) mem[fl_addr] = (mem.exists(fl_addr) ? mem[fl_addr] : 8'hff) & fl_wdata;
        if (fl_erase) for (int i = 0; i < span; i++) mem.delete(base + i);
        if (fl_erase_all) mem.delete();
    end
    // read data settles mid-cycle: the sequencer takes it at the next rising edge;
    // idle data inverts so a stale byte never looks valid
    always @(negedge pclk)
        fl_rdata <= fl_rd ? (mem.exists(fl_addr) ? mem[fl_addr] : 8'hff) : ~fl_rdata;
endmodule : fps_flash_model

// ---- sim/flash_program_erase_security_tb_top.sv ----
`timescale 1ns/1ps
module flash_program_erase_security_tb_top;
    import fps_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, cpu_req, cpu_ack;
    logic        cpu_stall, external_data_ram_req, external_data_ram_we, dbg_req, dbg_scratch, dbg_ack;
    logic        fl_rd, fl_prog, fl_erase, fl_erase_all;
    logic [7:0]  paddr, cpu_wdata, cpu_rdata, external_data_ram_wdata, external_data_ram_rdata, dbg_wdata, dbg_rdata;
    logic [7:0]  fl_wdata, fl_rdata, d, e;
    logic [15:0] cpu_addr, cpu_pc, external_data_ram_addr, dbg_addr;
    logic [16:0] fl_addr;
    logic [31:0] pwdata, prdata, seed;
    logic [23:0] xw;
    fps_kind_t   cpu_kind;
    fps_dbg_op_t dbg_op;
    logic [32:0] aq[$];
    logic [8:0]  cq[$], dq[$];
    int          failures, n_compared, n_erase, n_all, n_stall;
    fps_flash_seq #(.ERASE_CYCLES(20)) dut (.*);
    fps_flash_model flash (.*);
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [32:0] seen, input logic [32:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic end_of_test();
        if (failures == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    // one apb transfer; for reads v holds the expected {pslverr, prdata}
    task automatic apb(input logic wr, input logic [7:0] a, input logic [32:0] v);
        int n = 0;
        if (!wr) aq.push_back(v);
        @(posedge pclk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, v[31:0]};
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
        if (pready !== 1'b1) failures++;
        {psel, penable} <= 2'b00;
    endtask : apb
    // core request held until ack; v[8] asks for a data compare
    task automatic cpu(input fps_kind_t k, input logic [15:0] a, pc, input logic [7:0] wd,
                       input logic [8:0] v);
        int n = 0;
        cq.push_back(v);
        @(posedge pclk) {cpu_req, cpu_addr, cpu_pc, cpu_wdata} <= {1'b1, a, pc, wd};
        cpu_kind <= k;
        do @(posedge pclk); while (cpu_ack !== 1'b1 && ++n < 3000);
        if (cpu_ack !== 1'b1) failures++;
        cpu_req <= 1'b0;
    endtask : cpu
    // debug request held until ack; v[8] asks for a data compare
    task automatic dbg(input fps_dbg_op_t o, input logic [15:0] a, input logic [7:0] wd,
                       input logic [8:0] v);
        int n = 0;
        dq.push_back(v);
        @(posedge pclk) {dbg_req, dbg_addr, dbg_wdata} <= {1'b1, a, wd};
        dbg_op <= o;
        do @(posedge pclk); while (dbg_ack !== 1'b1 && ++n < 3000);
        if (dbg_ack !== 1'b1) failures++;
        dbg_req <= 1'b0;
    endtask : dbg
    ////////////////////////////////////////////////////////////////
    // result watcher, ram responder and pulse counters
    always @(posedge pclk) begin
        if (cpu_ack === 1'b1 && cq[0][8]) check(cpu_rdata, cq[0][7:0], "cpu_rdata");
        if (cpu_ack === 1'b1) void'(cq.pop_front());
        if (dbg_ack === 1'b1 && dq[0][8]) check(dbg_rdata, dq[0][7:0], "dbg_rdata");
        if (dbg_ack === 1'b1) void'(dq.pop_front());
        if (pready === 1'b1 && !pwrite)
            check({pslverr, prdata}, aq.pop_front(), "apb read");
        if (fl_erase === 1'b1) n_erase++;
        if (fl_erase_all === 1'b1) n_all++;
        if (cpu_stall === 1'b1) n_stall++;
        if (external_data_ram_req === 1'b1 && external_data_ram_we === 1'b1) xw <= {external_data_ram_addr, external_data_ram_wdata};
    end
    // ram answers within the strobe cycle, the sequencer takes it at the next edge
    always @(negedge pclk) external_data_ram_rdata <= external_data_ram_req ? external_data_ram_addr[7:0] ^ 8'h5a : ~external_data_ram_rdata;
    initial begin
        #(25 * 40000);
        failures++;
        end_of_test();
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'h973a4404;
        {presetn, psel, penable, pwrite, paddr, pwdata, cpu_req, cpu_addr, cpu_pc} = '0;
        {cpu_wdata, external_data_ram_rdata, dbg_req, dbg_addr, dbg_scratch, dbg_wdata, xw} = '0;
        cpu_kind = FPS_EXT_RD;
        dbg_op = FPS_DBG_RD;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        d = 8'($random(seed));
        e = 8'($random(seed));
        apb(1'b0, 8'h00, 33'h0);
        apb(1'b0, 8'h10, {1'b1, 32'h0});
        cpu(FPS_EXT_WR, 16'h1234, 16'h0, 8'ha5, 9'h0);
        check(xw, 24'h1234a5, "ram write");
        apb(1'b1, 8'h00, 33'h1);
        apb(1'b1, 8'h04, 33'h1);
        apb(1'b0, 8'h00, 33'h1);
        cpu(FPS_EXT_RD, 16'h0042, 16'h0, 8'h0, 9'h118);
        cpu(FPS_EXT_WR, 16'h2345, 16'h0, d, 9'h0);
        cpu(FPS_PROG_RD, 16'h2345, 16'h0, 8'h0, {1'b1, d});
        cpu(FPS_EXT_WR, 16'h2345, 16'h0, e, 9'h0);
        cpu(FPS_PROG_RD, 16'h2345, 16'h0, 8'h0, {1'b1, d & e});
        apb(1'b1, 8'h00, 33'h3);
        n_stall = 0;
        cpu(FPS_EXT_WR, 16'h2201, 16'h0, 8'h00, 9'h0);
        check(n_erase, 1, "page erases");
        check(n_stall, 20, "erase stall cycles");
        apb(1'b1, 8'h00, 33'h1);
        cpu(FPS_PROG_RD, 16'h2345, 16'h0, 8'h0, 9'h1ff);
        cpu(FPS_PROG_RD, 16'h2201, 16'h0, 8'h0, 9'h1ff);
        apb(1'b1, 8'h04, 33'h0);
        cpu(FPS_EXT_WR, 16'h3000, 16'h0, 8'h00, 9'h0);
        cpu(FPS_PROG_RD, 16'h3000, 16'h0, 8'h0, 9'h1ff);
        apb(1'b0, 8'h0c, 33'h2);
        apb(1'b1, 8'h0c, 33'h2);
        apb(1'b0, 8'h0c, 33'h0);
        apb(1'b1, 8'h04, 33'h1);
        apb(1'b1, 8'h00, 33'h3);
        cpu(FPS_EXT_WR, 16'hfa10, 16'h0, 8'h00, 9'h0);
        check(n_erase, 1, "lock page erases");
        cpu(FPS_PROG_RD, 16'hfc10, 16'h0, 8'h0, 9'h100);
        apb(1'b1, 8'h00, 33'h5);
        cpu(FPS_EXT_WR, 16'h0010, 16'h0, 8'h0f, 9'h0);
        cpu(FPS_PROG_RD, 16'h0010, 16'h0, 8'h0, 9'h10f);
        apb(1'b1, 8'h00, 33'h1);
        cpu(FPS_PROG_RD, 16'h0010, 16'h0, 8'h0, 9'h1ff);
        apb(1'b1, 8'h08, 33'h10);
        apb(1'b1, 8'h08, 33'h20);
        cpu(FPS_PROG_RD, 16'h0fff, 16'h1000, 8'h0, 9'h100);
        cpu(FPS_PROG_RD, 16'h0fff, 16'h0fff, 8'h0, 9'h1ff);
        cpu(FPS_PROG_RD, 16'h1800, 16'h2000, 8'h0, 9'h1ff);
        cpu(FPS_EXT_WR, 16'h0800, 16'h2000, 8'h00, 9'h0);
        cpu(FPS_PROG_RD, 16'h0800, 16'h0, 8'h0, 9'h1ff);
        dbg(FPS_DBG_WR, 16'hfbff, 8'hfe, 9'h0);
        dbg(FPS_DBG_RD, 16'h0042, 8'h0, 9'h100);
        dbg(FPS_DBG_RD, 16'hfbff, 8'h0, 9'h1fe);
        dbg(FPS_DBG_ER, 16'hfbfe, 8'h0, 9'h0);
        check(n_all, 1, "full erases");
        dbg(FPS_DBG_RD, 16'h0042, 8'h0, 9'h1ff);
        end_of_test();
    end
endmodule : flash_program_erase_security_tb_top
